// ---- common/dct_regs.svh ----
// Purpose: register indices, field positions, reset values and sizes
//          of the debug compare and trace block
// Assumes: one byte register per index on the register port
// Notes:   definitions only
`ifndef DCT_REGS_SVH
`define DCT_REGS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define DCT_IDX_CMP_A_HI  4'h0
`define DCT_IDX_CMP_A_LO  4'h1
`define DCT_IDX_CMP_B_HI  4'h2
`define DCT_IDX_CMP_B_LO  4'h3
`define DCT_IDX_TRC_HI    4'h4
`define DCT_IDX_TRC_LO    4'h5
`define DCT_IDX_CTRL      4'h6
`define DCT_IDX_FRC_RST   4'h9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCT_FRC_BIT       0

// ----------------------------------------------------------------
// reset and read values
// ----------------------------------------------------------------
`define DCT_CTRL_RST      8'h00
`define DCT_CMP_RST       8'h00
`define DCT_FRC_READ      8'h00
`define DCT_ZERO_BYTE     8'h00
`define DCT_WORD_RST      16'h0000

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DCT_FIFO_DEPTH    8

`endif

// ---- common/dct_pkg.sv ----
// Purpose: types of the debug compare and trace block
// Assumes: field order of the control struct follows bit 7 down to 0
// Notes:   constants live in dct_regs.svh
`default_nettype none

package dct_pkg;

    // control register image, bit 7 first
    typedef struct packed {
        logic module_enable;
        logic arm;
        logic break_tag_select;
        logic break_request_enable;
        logic comp_a_dir_value;
        logic comp_a_dir_qualify;
        logic comp_b_dir_value;
        logic comp_b_dir_qualify;
    } dct_ctrl_s;

    // one register access from the cpu or the background link
    typedef struct packed {
        logic [3:0] idx;
        logic       wr;
        logic       rd;
        logic       bdm;
        logic [7:0] wdata;
    } dct_bus_req_s;

    // observed cpu bus cycle
    typedef struct packed {
        logic        valid;
        logic        rw;
        logic        opfetch;
        logic [15:0] addr;
        logic [7:0]  data;
    } dct_cpu_obs_s;

    typedef enum logic [1:0] {
        RUN_IDLE   = 2'b00,
        RUN_WAIT   = 2'b01,
        RUN_BEGIN  = 2'b10,
        RUN_END    = 2'b11
    } dct_run_e;

endpackage : dct_pkg

`default_nettype wire

// ---- hw/dct_addr_match.sv ----
// Purpose: one 16-bit address comparator with access direction filter
// Assumes: rw high marks a read cycle
// Notes:   combinational; the top feeds match_o unregistered into its run logic
`timescale 1ns/100ps
`default_nettype none

module dct_addr_match
    import dct_pkg::*;
(
    // compare setup
    input  wire logic [15:0] cmp_val_i,
    input  wire logic        dir_qualify_i,
    input  wire logic        dir_value_i,
    // observed cycle
    input  wire logic        valid_i,
    input  wire logic        rw_i,
    input  wire logic [15:0] addr_i,
    // result
    output logic             match_o
);

    logic addr_eq;
    logic dir_ok;

    assign addr_eq = (addr_i == cmp_val_i);
    // direction only counts when qualified: 1 reads, 0 writes
    assign dir_ok  = !dir_qualify_i || (rw_i == dir_value_i);
    assign match_o = valid_i && addr_eq && dir_ok;

endmodule : dct_addr_match

`default_nettype wire

// ---- hw/dct_debug_top.sv ----
// Purpose: debug comparators, trace buffer, control and forced reset
// Assumes: register port is byte wide, read data one cycle after rd
// Notes:   trigger and status registers live outside this block
//
// Function
// - forced reset written only by background commands
// - forced reset register always reads zero
// - host bit 0 write forces system reset
// - comparator bytes reset to zero, always readable
// - comparator writes only while not armed
// - trace high port read-only, zero event-only
// - high read holds, unarmed low read advances buffer
// - event-only modes store 8-bit values only
// - unarmed low read stores last opcode address
// - unarmed buffer acts as eight-deep delay line
// - control register accessible at any time
// - enable cannot set while device secured
// - arm write starts run; done or clear stops
// - bit 5 selects tag or force break
// - break on end trigger or begin full
// - trigger qualification leaves break timing unchanged
// - comparator A direction qualified by bits 2,3
// - comparator B direction qualified by bits 0,1
// - eight byte registers in the memory map
// - run ends on full in begin runs or on end trigger
// - at most eight words, count drops only when arming clears it
`timescale 1ns/100ps
`default_nettype none
`include "dct_regs.svh"

module dct_debug_top
    import dct_pkg::*;
#(
    parameter int DEPTH = `DCT_FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    // register port
    input  wire dct_bus_req_s bus_req_i,
    output logic [7:0]        bus_rdata_o,
    // observed cpu bus
    input  wire dct_cpu_obs_s cpu_obs_i,
    // mode inputs
    input  wire logic         secure_i,
    input  wire logic         event_only_i,
    input  wire logic         begin_trace_i,
    input  wire logic         trigger_qualify_select_i,
    // results
    output logic              host_reset_request_o,
    output logic              break_req_o,
    output logic              break_tag_o,
    output logic              armed_flag_o,
    output logic [3:0]        valid_word_count_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // the count is four bits wide and full must be reachable
    if (DEPTH < 2 || DEPTH > 15)
    begin : g_bad_depth
        $error("dct_debug_top: DEPTH must lie in 2..15");
    end

    localparam logic [3:0] DEPTH_C = 4'(DEPTH);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    dct_ctrl_s   ctrl_reg;
    dct_ctrl_s   ctrl_next;
    logic [7:0]  cmp_a_hi_reg;
    logic [7:0]  cmp_a_lo_reg;
    logic [7:0]  cmp_b_hi_reg;
    logic [7:0]  cmp_b_lo_reg;
    logic [15:0] fifo_reg [DEPTH];
    logic [15:0] last_op_reg;
    logic [3:0]  count_reg;
    dct_run_e    run_reg;
    dct_run_e    run_next;
    logic [7:0]  rdata_reg;
    logic        frc_reg;
    logic        brk_reg;
    logic        brk_tag_reg;

    logic        wr_cmp_ok;
    logic        wr_ctrl;
    logic        rd_low;
    logic        arm_start;
    logic        match_a;
    logic        match_b;
    logic        hit_a;
    logic        hit_b;
    logic        qual_ok;
    logic        trig;
    logic        store_en;
    logic [15:0] store_word;
    logic        run_done;
    logic        shift_en;
    logic [15:0] shift_word;

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // comparator bytes are frozen while armed
    assign wr_cmp_ok = bus_req_i.wr && !ctrl_reg.arm;
    assign wr_ctrl   = bus_req_i.wr
                       && (bus_req_i.idx == `DCT_IDX_CTRL);
    assign rd_low    = bus_req_i.rd
                       && (bus_req_i.idx == `DCT_IDX_TRC_LO);

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    dct_addr_match u_match_a (
        .cmp_val_i     ({cmp_a_hi_reg, cmp_a_lo_reg}),
        .dir_qualify_i (ctrl_reg.comp_a_dir_qualify),
        .dir_value_i   (ctrl_reg.comp_a_dir_value),
        .valid_i       (cpu_obs_i.valid),
        .rw_i          (cpu_obs_i.rw),
        .addr_i        (cpu_obs_i.addr),
        .match_o       (match_a)
    );

    dct_addr_match u_match_b (
        .cmp_val_i     ({cmp_b_hi_reg, cmp_b_lo_reg}),
        .dir_qualify_i (ctrl_reg.comp_b_dir_qualify),
        .dir_value_i   (ctrl_reg.comp_b_dir_value),
        .valid_i       (cpu_obs_i.valid),
        .rw_i          (cpu_obs_i.rw),
        .addr_i        (cpu_obs_i.addr),
        .match_o       (match_b)
    );

    // tag qualification only filters which cycles can trigger;
    // break timing still follows the run end below
    assign qual_ok = !trigger_qualify_select_i || cpu_obs_i.opfetch;
    assign hit_a   = ctrl_reg.arm && match_a && qual_ok;
    assign hit_b   = ctrl_reg.arm && match_b && qual_ok;
    assign trig    = hit_a || hit_b;

    // ------------------------------------------------------------
    // run sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        store_en   = 1'b0;
        store_word = {8'h00, cpu_obs_i.data};
        run_done   = 1'b0;
        run_next   = run_reg;
        case (run_reg)
            RUN_IDLE:
            begin
                run_next = RUN_IDLE;
            end
            RUN_WAIT:
            begin
                if (trig)
                begin
                    run_next = RUN_BEGIN;
                end
            end
            RUN_BEGIN:
            begin
                if (event_only_i)
                begin
                    // only the data byte is kept
                    store_en   = hit_b;
                    store_word = {8'h00, cpu_obs_i.data};
                end
                else
                begin
                    store_en   = cpu_obs_i.valid && cpu_obs_i.opfetch;
                    store_word = cpu_obs_i.addr;
                end
                if (store_en && (count_reg == DEPTH_C - 4'h1))
                begin
                    run_done = 1'b1;
                    run_next = RUN_IDLE;
                end
            end
            RUN_END:
            begin
                // circular fill until the trigger ends capture
                store_en   = cpu_obs_i.valid && cpu_obs_i.opfetch;
                store_word = cpu_obs_i.addr;
                if (trig)
                begin
                    run_done = 1'b1;
                    run_next = RUN_IDLE;
                end
            end
            default:
            begin
                run_next = RUN_IDLE;
            end
        endcase
        if (arm_start)
        begin
            store_en = 1'b0;
            run_done = 1'b0;
            if (event_only_i)
            begin
                run_next = RUN_BEGIN;
            end
            else if (begin_trace_i)
            begin
                run_next = RUN_WAIT;
            end
            else
            begin
                run_next = RUN_END;
            end
        end
        else if (!ctrl_next.arm)
        begin
            run_next = RUN_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            run_reg <= RUN_IDLE;
        end
        else
        begin
            run_reg <= run_next;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    assign arm_start = wr_ctrl && ctrl_next.arm && !ctrl_reg.arm;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl)
        begin
            // a software write wins over a run ending that cycle
            ctrl_next = dct_ctrl_s'(bus_req_i.wdata);
            ctrl_next.module_enable = bus_req_i.wdata[7]
                                      && !secure_i;
        end
        else if (run_done)
        begin
            ctrl_next.arm = 1'b0;
        end
        // arming needs an enabled module; disabling stops a run
        if (!ctrl_next.module_enable)
        begin
            ctrl_next.arm = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_reg <= dct_ctrl_s'(`DCT_CTRL_RST);
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ------------------------------------------------------------
    // comparator registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            cmp_a_hi_reg <= `DCT_CMP_RST;
            cmp_a_lo_reg <= `DCT_CMP_RST;
            cmp_b_hi_reg <= `DCT_CMP_RST;
            cmp_b_lo_reg <= `DCT_CMP_RST;
        end
        else if (wr_cmp_ok)
        begin
            case (bus_req_i.idx)
                `DCT_IDX_CMP_A_HI: cmp_a_hi_reg <= bus_req_i.wdata;
                `DCT_IDX_CMP_A_LO: cmp_a_lo_reg <= bus_req_i.wdata;
                `DCT_IDX_CMP_B_HI: cmp_b_hi_reg <= bus_req_i.wdata;
                `DCT_IDX_CMP_B_LO: cmp_b_lo_reg <= bus_req_i.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // trace buffer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            last_op_reg <= `DCT_WORD_RST;
        end
        else if (cpu_obs_i.valid && cpu_obs_i.opfetch)
        begin
            last_op_reg <= cpu_obs_i.addr;
        end
    end

    // an armed buffer never advances on reads, so reading early
    // returns the same head word over and over
    assign shift_en   = store_en
                        || (rd_low && !ctrl_reg.arm);
    // unarmed low reads push the last opcode address in at the
    // tail, giving a delay line as deep as the buffer
    assign shift_word = store_en ? store_word
                                 : last_op_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                fifo_reg[i] <= `DCT_WORD_RST;
            end
        end
        else if (shift_en)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                fifo_reg[i] <= fifo_reg[i + 1];
            end
            fifo_reg[DEPTH - 1] <= shift_word;
        end
    end

    // counts captured words; reads leave it alone
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            count_reg <= 4'h0;
        end
        else if (arm_start)
        begin
            count_reg <= 4'h0;
        end
        else if (store_en && (count_reg < DEPTH_C))
        begin
            count_reg <= count_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_reg <= `DCT_ZERO_BYTE;
        end
        else if (bus_req_i.rd)
        begin
            case (bus_req_i.idx)
                `DCT_IDX_CMP_A_HI: rdata_reg <= cmp_a_hi_reg;
                `DCT_IDX_CMP_A_LO: rdata_reg <= cmp_a_lo_reg;
                `DCT_IDX_CMP_B_HI: rdata_reg <= cmp_b_hi_reg;
                `DCT_IDX_CMP_B_LO: rdata_reg <= cmp_b_lo_reg;
                `DCT_IDX_TRC_HI:
                begin
                    rdata_reg <= event_only_i ? `DCT_ZERO_BYTE
                                 : fifo_reg[0][15:8];
                end
                `DCT_IDX_TRC_LO:   rdata_reg <= fifo_reg[0][7:0];
                `DCT_IDX_CTRL:     rdata_reg <= ctrl_reg;
                `DCT_IDX_FRC_RST:  rdata_reg <= `DCT_FRC_READ;
                default:           rdata_reg <= `DCT_ZERO_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // forced system reset
    // ------------------------------------------------------------
    // program writes are dropped; only the background link counts
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            frc_reg <= 1'b0;
        end
        else
        begin
            frc_reg <= bus_req_i.wr && bus_req_i.bdm
                       && (bus_req_i.idx == `DCT_IDX_FRC_RST)
                       && bus_req_i.wdata[`DCT_FRC_BIT];
        end
    end

    // ------------------------------------------------------------
    // break request
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            brk_reg     <= 1'b0;
            brk_tag_reg <= 1'b0;
        end
        else
        begin
            brk_reg     <= run_done
                           && ctrl_reg.break_request_enable;
            brk_tag_reg <= ctrl_reg.break_request_enable
                           && ctrl_reg.break_tag_select;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_rdata_o          = rdata_reg;
    assign host_reset_request_o = frc_reg;
    assign break_req_o          = brk_reg;
    assign break_tag_o          = brk_tag_reg;
    assign armed_flag_o         = ctrl_reg.arm;
    assign valid_word_count_o   = count_reg;

endmodule : dct_debug_top

`default_nettype wire

// ---- verif/dct_debug_checker.sv ----
// Purpose: port assertions for dct_debug_top
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the top
`timescale 1ns/100ps
`default_nettype none

module dct_debug_checker
    import dct_pkg::*;
#(
    parameter int DEPTH = 8
)
(
    // clock and reset
    input wire logic         ref_clk_i,
    input wire logic         sys_rst_i,
    // register port
    input wire dct_bus_req_s bus_req_i,
    input wire logic [7:0]   bus_rdata_o,
    // cpu and modes
    input wire dct_cpu_obs_s cpu_obs_i,
    input wire logic         secure_i,
    input wire logic         event_only_i,
    input wire logic         begin_trace_i,
    input wire logic         trigger_qualify_select_i,
    // results
    input wire logic         host_reset_request_o,
    input wire logic         break_req_o,
    input wire logic         break_tag_o,
    input wire logic         armed_flag_o,
    input wire logic [3:0]   valid_word_count_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    wire logic       rd_s = bus_req_i.rd;
    wire logic       wr_s = bus_req_i.wr;
    wire logic [3:0] ix_s = bus_req_i.idx;

    // --------------------------------------------------------------
    // sequences
    // --------------------------------------------------------------
    sequence host_rst_wr_s;
        wr_s && bus_req_i.bdm && ix_s == 4'h9 && bus_req_i.wdata[0];
    endsequence
    sequence run_end_s;
        $fell(armed_flag_o);
    endsequence

    frc_host_a: assert property (host_rst_wr_s |=> host_reset_request_o)
        else $error("host reset write gave no reset pulse");
    frc_user_a: assert property (host_reset_request_o |->
        $past(wr_s && bus_req_i.bdm && ix_s == 4'h9 && bus_req_i.wdata[0]))
        else $error("reset pulse without a host write");
    frc_read_a: assert property (rd_s && ix_s == 4'h9 |=> bus_rdata_o == 8'h00)
        else $error("forced reset register read not zero");
    unmap_read_a: assert property (rd_s && (ix_s == 4'h7 || ix_s == 4'h8
        || ix_s > 4'h9) |=> bus_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    trace_hi_a: assert property (rd_s && ix_s == 4'h4 && event_only_i
        |=> bus_rdata_o == 8'h00)
        else $error("trace high not zero in event-only mode");
    arm_start_a: assert property ($rose(armed_flag_o) |-> $past(wr_s
        && ix_s == 4'h6 && bus_req_i.wdata[7:6] == 2'b11 && !secure_i))
        else $error("armed without an enabling write");
    arm_stop_a: assert property (wr_s && ix_s == 4'h6 && !bus_req_i.wdata[6]
        |=> !armed_flag_o)
        else $error("arm clear write did not stop run");
    break_end_a: assert property (break_req_o |-> run_end_s)
        else $error("break without run end");
    break_pulse_a: assert property (break_req_o |=> !break_req_o)
        else $error("break request longer than one cycle");
    count_max_a: assert property (valid_word_count_o <= DEPTH)
        else $error("word count above depth");
    count_keep_a: assert property (rd_s && ix_s == 4'h5 && !armed_flag_o
        |=> valid_word_count_o >= $past(valid_word_count_o))
        else $error("word count fell on read");
    rdata_hold_a: assert property (!rd_s |=> $stable(bus_rdata_o))
        else $error("read data changed without a read");
endmodule : dct_debug_checker

bind dct_debug_top dct_debug_checker #(.DEPTH(DEPTH)) u_chk (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus_req_i(bus_req_i),
    .bus_rdata_o(bus_rdata_o), .cpu_obs_i(cpu_obs_i), .secure_i(secure_i),
    .event_only_i(event_only_i), .begin_trace_i(begin_trace_i),
    .trigger_qualify_select_i(trigger_qualify_select_i),
    .host_reset_request_o(host_reset_request_o), .break_req_o(break_req_o),
    .break_tag_o(break_tag_o), .armed_flag_o(armed_flag_o),
    .valid_word_count_o(valid_word_count_o));

`default_nettype wire

// ---- verif/dct_cpu_model.sv ----
// Purpose: cpu bus model seen by the debug block
// Assumes: one bench-requested cycle per valid clock
// Notes:   idle bus never repeats the last cycle
`timescale 1ns/100ps
`default_nettype none

module dct_cpu_model
    import dct_pkg::*;
(
    // clock
    input  wire logic         ref_clk_i,
    // cycle request
    input  wire logic         cyc_v_i,
    input  wire dct_cpu_obs_s cyc_i,
    // observed bus
    output dct_cpu_obs_s      cpu_obs_o
);
    dct_cpu_obs_s last_reg = '0;

    always_ff @(posedge ref_clk_i)
        if (cyc_v_i)
            last_reg <= cyc_i;

    // idle shows the inverse so a stale match cannot pass unseen
    always_comb
    begin
        cpu_obs_o = cyc_v_i ? cyc_i : ~last_reg;
        if (!cyc_v_i)
            cpu_obs_o.valid = 1'b0;
    end
endmodule : dct_cpu_model

`default_nettype wire

// ---- verif/test_debug_compare_trace_regs.sv ----
// Purpose: self-checking bench for dct_debug_top
// Assumes: read data checked one cycle after the read is taken
// Notes:   trigger qualify is raised for the second run only, begin trace with event-only
`timescale 1ns/100ps
`default_nettype none
`include "dct_regs.svh"

module test_debug_compare_trace_regs
    import dct_pkg::*;
;
    logic         ref_clk_i, sys_rst_i, secure_i, event_only_i, cyc_v;
    dct_bus_req_s bus_req_i;
    dct_cpu_obs_s cyc, cpu_obs_i;
    logic [7:0]   bus_rdata_o, v [8];
    logic         host_reset_request_o, break_req_o, break_tag_o;
    logic         armed_flag_o, pend, begin_trace_i, trigger_qualify_select_i;
    logic [3:0]   valid_word_count_o;
    logic [8:0]   exp_q [$];
    logic [8:0]   note;
    logic [15:0]  a [16];
    logic [15:0]  ca, cb, ad;
    int           err_total, total_checks, cycles, i;
    localparam logic [7:0] RUN_CTRL [3] = '{8'hFC, 8'hD1, 8'hE1};

    dct_debug_top DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o),
        .cpu_obs_i(cpu_obs_i), .secure_i(secure_i),
        .event_only_i(event_only_i), .begin_trace_i(begin_trace_i),
        .trigger_qualify_select_i(trigger_qualify_select_i),
        .host_reset_request_o(host_reset_request_o),
        .break_req_o(break_req_o), .break_tag_o(break_tag_o),
        .armed_flag_o(armed_flag_o),
        .valid_word_count_o(valid_word_count_o));
    dct_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .cyc_v_i(cyc_v),
        .cyc_i(cyc), .cpu_obs_o(cpu_obs_i));

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] e);
        total_checks++;
        if (seen !== e)
        begin
            $display("mismatch at %0t: got %h want %h", $time, seen, e);
            err_total++;
        end
    endtask : check

    task automatic results;
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    task automatic acc(input logic [3:0] ix, input logic w, input logic bdm,
        input logic [7:0] d, input logic chk, input logic [7:0] e);
        @(posedge ref_clk_i);
        bus_req_i <= '{idx: ix, wr: w, rd: !w, bdm: bdm, wdata: d};
        if (!w)
            exp_q.push_back({chk, e});
        @(posedge ref_clk_i);
        bus_req_i <= '0;
    endtask : acc

    task automatic wr(input logic [3:0] ix, input logic [7:0] d);
        acc(ix, 1'b1, 1'b0, d, 1'b0, 8'h00);
    endtask : wr

    task automatic rd(input logic [3:0] ix, input logic [7:0] e);
        acc(ix, 1'b0, 1'b0, 8'h00, 1'b1, e);
    endtask : rd

    task automatic cpu(input logic [15:0] ad_i, input logic rw,
        input logic op, input logic [7:0] d);
        @(posedge ref_clk_i);
        cyc   <= '{valid: 1'b1, rw: rw, opfetch: op, addr: ad_i, data: d};
        cyc_v <= 1'b1;
        @(posedge ref_clk_i);
        cyc_v <= 1'b0;
    endtask : cpu

    initial
    begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // read results land one cycle after the read is taken
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            results();
        end
        if (pend && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (note[8]) check(bus_rdata_o, note[7:0]);
        end
        pend <= bus_req_i.rd;
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        bus_req_i = '0; cyc = '0; cyc_v = 1'b0; pend = 1'b0;
        secure_i = 1'b0; event_only_i = 1'b0; sys_rst_i = 1'b1;
        begin_trace_i = 1'b0; trigger_qualify_select_i = 1'b0;
        void'($urandom(32'h2777));
        repeat (12) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        for (i = 0; i < 16; i++)
            rd(i[3:0], 8'h00);
        for (i = 0; i < 4; i++)
        begin
            v[i] = 8'($urandom);
            wr(i[3:0], v[i]);
            rd(i[3:0], v[i]);
        end
        acc(`DCT_IDX_FRC_RST, 1'b1, 1'b0, 8'h01, 1'b0, 8'h00);
        @(negedge ref_clk_i);
        check(host_reset_request_o, 8'h00);
        acc(`DCT_IDX_FRC_RST, 1'b1, 1'b1, 8'h01, 1'b0, 8'h00);
        @(negedge ref_clk_i);
        check(host_reset_request_o, 8'h01);
        rd(`DCT_IDX_FRC_RST, 8'h00);
        secure_i <= 1'b1;
        wr(4'h6, 8'h80);
        rd(4'h6, 8'h00);
        secure_i <= 1'b0;
        wr(4'h6, 8'hC0);
        @(negedge ref_clk_i);
        check(armed_flag_o, 8'h01);
        wr(4'h0, ~v[0]);
        rd(4'h0, v[0]);
        rd(4'h6, 8'hC0);
        wr(4'h6, 8'h80);
        @(negedge ref_clk_i);
        check(armed_flag_o, 8'h00);
        // profiling: each low read shifts in the last opcode address
        for (i = 0; i < 16; i++)
        begin
            a[i] = 16'($urandom);
            cpu(a[i], 1'b1, 1'b1, a[i][7:0]);
            repeat (2) acc(4'h4, 1'b0, 1'b0, 8'h00, i >= 8,
                a[(i + 8) % 16][15:8]);
            acc(4'h5, 1'b0, 1'b0, 8'h00, i >= 8, a[(i + 8) % 16][7:0]);
        end
        ca = 16'($urandom);
        cb = ca ^ 16'h8000;
        wr(4'h0, ca[15:8]);
        wr(4'h1, ca[7:0]);
        wr(4'h2, cb[15:8]);
        wr(4'h3, cb[7:0]);
        for (i = 0; i < 3; i++)
        begin
            ad = (i == 0) ? ca : cb;
            trigger_qualify_select_i <= (i == 1);
            wr(4'h6, RUN_CTRL[i]);
            cpu(ad, i != 0, 1'b0, 8'h00);
            @(negedge ref_clk_i);
            check(armed_flag_o, 8'h01);
            cpu(ad, i == 0, 1'b1, 8'h00);
            @(negedge ref_clk_i);
            check(armed_flag_o, 8'h00);
            check(break_req_o, i < 2);
            check(break_tag_o, i == 0);
        end
        event_only_i <= 1'b1;
        begin_trace_i <= 1'b1;
        wr(4'h6, 8'hC0);
        for (i = 0; i < 8; i++)
        begin
            v[i] = 8'($urandom);
            cpu(cb, 1'b1, 1'b0, v[i]);
        end
        @(negedge ref_clk_i);
        check(armed_flag_o, 8'h00);
        check(valid_word_count_o, `DCT_FIFO_DEPTH);
        // buffer read only once the run has ended
        wr(4'h4, 8'h5A);
        for (i = 0; i < 8; i++)
        begin
            rd(4'h4, 8'h00);
            rd(4'h5, v[i]);
        end
        repeat (3) @(posedge ref_clk_i);
        results();
    end
endmodule : test_debug_compare_trace_regs

`default_nettype wire
